// file: src/twsc_defines.svh
// constants for the three-wire serial channel: offsets, fields, resets, counts
`ifndef TWSC_DEFINES_SVH
`define TWSC_DEFINES_SVH
// register addresses on the internal bus
`define TWSC_MODE_ADDR 16'hFF68
`define TWSC_SHIFT_ADDR 16'hFF69
`define TWSC_AUTO_ADDR 16'hFF6A
`define TWSC_COUNT_ADDR 16'hFF6C
`define TWSC_STAT_ADDR 16'hFF6D
`define TWSC_BUF_BASE 16'hFAC0
// buffer span in bytes, and its address width
`define TWSC_BUF_BYTES 32
`define TWSC_BUF_AW 5
// reset values
`define TWSC_MODE_RESET 8'h00
`define TWSC_AUTO_RESET 8'h00
`define TWSC_COUNT_RESET 8'h00
// writable bits of each register
`define TWSC_MODE_WMASK 8'hE3
`define TWSC_AUTO_WMASK 8'h86
`define TWSC_COUNT_WMASK 8'h1F
// status and auto-control bit positions
`define TWSC_STAT_IRQ_BIT 0
`define TWSC_AUTO_RUN_BIT 3
// clock select code for the timer two output
`define TWSC_SEL_TIMER 2'h2
// bits in a byte, last bit index
`define TWSC_LAST_BIT 3'h7
`endif

// file: src/twsc_pkg.sv
// types shared by the three-wire serial channel
package twsc_pkg;
  // mode register layout
  typedef struct packed {
    logic       enable;
    logic       lsb_first;
    logic       auto_mode;
    logic [2:0] zero;
    logic [1:0] clk_sel;
  } twsc_mode_t;
  // automatic transfer control layout
  typedef struct packed {
    logic       receive_enable;
    logic [2:0] zero_hi;
    logic       running;
    logic       strobe_en;
    logic       busy_en;
    logic       zero_lo;
  } twsc_auto_t;
  // drive of one pin
  typedef struct packed {
    logic o;
    logic oe;
  } twsc_pin_t;
  // channel sequencer states
  typedef enum logic [1:0] {
    TWSC_IDLE,
    TWSC_XFER,
    TWSC_STROBE,
    TWSC_WAIT
  } twsc_state_t;
endpackage : twsc_pkg

// file: src/twsc_sync2.sv
// two flip-flop synchroniser for one pin input
`timescale 1ns/1ns
module twsc_sync2 (
  input wire logic i_core_clk,
  input wire logic i_nrst,
  input wire logic i_async,
  output logic o_sync
);
  logic meta; // first stage, read only by the second
  // two stages, idle level high
  always_ff @(posedge i_core_clk)
  begin
    if (!i_nrst)
    begin
      meta <= 1'b1;
      o_sync <= 1'b1;
    end
    else
    begin
      meta <= i_async;
      o_sync <= meta;
    end
  end
endmodule : twsc_sync2

// file: src/twsc_channel.sv
// three-wire serial channel with plain and automatic multi-byte transfer
`timescale 1ns/1ns
`include "twsc_defines.svh"
module twsc_channel (
  input wire logic i_core_clk,
  input wire logic i_nrst,
  input wire logic [15:0] i_addr,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic [7:0] i_wdata,
  input wire logic i_timer_two_tick,
  input wire logic i_prescale_tick,
  input wire logic i_serial_clock_pin,
  input wire logic i_serial_in_pin,
  input wire logic i_busy_pin,
  output logic [7:0] o_rdata,
  output twsc_pkg::twsc_pin_t o_serial_clock_pin,
  output twsc_pkg::twsc_pin_t o_serial_out_pin,
  output twsc_pkg::twsc_pin_t o_strobe_pin,
  output logic o_serial_in_used,
  output logic o_busy_in_used,
  output logic o_channel_irq_flag
);
  // registers
  twsc_pkg::twsc_mode_t serial_mode_control; // mode register
  twsc_pkg::twsc_auto_t auto_transfer_control; // auto control
  logic [`TWSC_BUF_AW-1:0] last_index; // last byte index
  logic [7:0] shift_register; // physical shift order
  logic [7:0] xfer_buf [`TWSC_BUF_BYTES]; // auto data buffer
  logic so_latch; // transmit bit latch
  logic sck_q; // internal serial clock level
  logic [2:0] bit_cnt; // serial clock counter
  logic [`TWSC_BUF_AW-1:0] ptr; // current buffer byte
  twsc_pkg::twsc_state_t state; // sequencer state
  logic sck_prev; // last synced clock level
  // synchronised pins
  logic sck_s;
  logic si_s;
  logic busy_s;

  // pin synchronisers
  twsc_sync2 u_sync_sck (
    .i_core_clk (i_core_clk),
    .i_nrst (i_nrst),
    .i_async (i_serial_clock_pin),
    .o_sync (sck_s)
  );
  twsc_sync2 u_sync_si (
    .i_core_clk (i_core_clk),
    .i_nrst (i_nrst),
    .i_async (i_serial_in_pin),
    .o_sync (si_s)
  );
  twsc_sync2 u_sync_busy (
    .i_core_clk (i_core_clk),
    .i_nrst (i_nrst),
    .i_async (i_busy_pin),
    .o_sync (busy_s)
  );

  // decode of field bits
  wire en = serial_mode_control.enable;
  wire lsb = serial_mode_control.lsb_first;
  wire auto_transfer_enable = serial_mode_control.auto_mode; // plain or auto
  wire ext = ~serial_mode_control.clk_sel[1]; // external clock
  wire re = auto_transfer_control.receive_enable;
  wire stb_en = auto_transfer_control.strobe_en & ~ext;
  wire bsy_en = auto_transfer_control.busy_en & ~ext;

  // bus decode
  wire wr_mode = i_wr & (i_addr == `TWSC_MODE_ADDR);
  wire wr_shift = i_wr & (i_addr == `TWSC_SHIFT_ADDR);
  wire wr_auto = i_wr & (i_addr == `TWSC_AUTO_ADDR);
  wire wr_count = i_wr & (i_addr == `TWSC_COUNT_ADDR);
  wire wr_stat = i_wr & (i_addr == `TWSC_STAT_ADDR);
  // buffer window: upper address bits equal those of the base
  wire in_buf = (i_addr[15:`TWSC_BUF_AW] == 11'(`TWSC_BUF_BASE >> `TWSC_BUF_AW));
  wire [`TWSC_BUF_AW-1:0] buf_idx = i_addr[`TWSC_BUF_AW-1:0];
  wire idle = (state == twsc_pkg::TWSC_IDLE);
  wire wr_buf = i_wr & in_buf & idle;

  // bit-order view for the bus
  wire [7:0] wdata_rev = {i_wdata[0], i_wdata[1], i_wdata[2], i_wdata[3],
                          i_wdata[4], i_wdata[5], i_wdata[6], i_wdata[7]};
  wire [7:0] sr_rev = {shift_register[0], shift_register[1],
                       shift_register[2], shift_register[3],
                       shift_register[4], shift_register[5],
                       shift_register[6], shift_register[7]};
  wire [7:0] wr_view = lsb ? wdata_rev : i_wdata;
  wire [7:0] rd_view = lsb ? sr_rev : shift_register;

  // serial clock source and edges
  wire int_tick = (serial_mode_control.clk_sel == `TWSC_SEL_TIMER) ?
                  i_timer_two_tick : i_prescale_tick;
  wire xfer = (state == twsc_pkg::TWSC_XFER);
  wire ext_fall = sck_prev & ~sck_s;
  wire ext_rise = ~sck_prev & sck_s;
  wire fall_ev = xfer & (ext ? ext_fall : (int_tick & sck_q));
  wire rise_ev = xfer & (ext ? ext_rise : (int_tick & ~sck_q));
  wire byte_done = rise_ev & (bit_cnt == `TWSC_LAST_BIT);

  // start: enabled, idle, internal clock or clock pin high
  // a write while the pin is low loads the register but starts nothing, not queued
  wire start = wr_shift & en & idle & (~ext | sck_s);
  // automatic sequence bookkeeping
  wire last_byte = (ptr == last_index);
  wire auto_more = auto_transfer_enable & ~last_byte; // more bytes to move
  wire [`TWSC_BUF_AW-1:0] ptr_inc = ptr + `TWSC_BUF_AW'(1);
  wire [7:0] rx_byte = {shift_register[6:0], si_s};
  wire can_load = ~(bsy_en & busy_s); // far end ready

  // next state of the sequencer
  twsc_pkg::twsc_state_t next_state;
  always_comb
  begin
    next_state = state;
    case (state)
      twsc_pkg::TWSC_IDLE:
        if (start)
          next_state = twsc_pkg::TWSC_XFER;
      twsc_pkg::TWSC_XFER:
        if (byte_done)
        begin
          // stop after eight bits unless more to stream
          if (!auto_more)
            next_state = twsc_pkg::TWSC_IDLE;
          else if (stb_en)
            next_state = twsc_pkg::TWSC_STROBE;
          else
            next_state = twsc_pkg::TWSC_WAIT;
        end
      // strobe lasts one rate tick
      twsc_pkg::TWSC_STROBE:
        if (int_tick)
          next_state = twsc_pkg::TWSC_WAIT;
      // hold the next byte while the far end is busy
      twsc_pkg::TWSC_WAIT:
        if (can_load)
          next_state = twsc_pkg::TWSC_XFER;
      default:
        next_state = twsc_pkg::TWSC_IDLE;
    endcase
    if (!en)
      next_state = twsc_pkg::TWSC_IDLE; // stopped mode
  end
  // reload from the buffer as the wait ends
  wire load_next = (state == twsc_pkg::TWSC_WAIT) & can_load & en;

  // sequencer state
  always_ff @(posedge i_core_clk)
  begin
    if (!i_nrst)
      state <= twsc_pkg::TWSC_IDLE;
    else
      state <= next_state;
  end

  // mode register; reset clears it
  always_ff @(posedge i_core_clk)
  begin
    if (!i_nrst)
      serial_mode_control <= `TWSC_MODE_RESET;
    else if (wr_mode)
      serial_mode_control <= i_wdata & `TWSC_MODE_WMASK; // zeros kept
  end

  // auto control; running bit tracks the stream
  always_ff @(posedge i_core_clk)
  begin
    if (!i_nrst)
      auto_transfer_control <= `TWSC_AUTO_RESET;
    else
    begin
      if (wr_auto)
        auto_transfer_control <= (i_wdata & `TWSC_AUTO_WMASK) |
          {4'h0, auto_transfer_control.running, 3'h0};
      // running set on an automatic start, cleared at the end
      if (start & auto_transfer_enable)
        auto_transfer_control.running <= 1'b1;
      else if (next_state == twsc_pkg::TWSC_IDLE)
        auto_transfer_control.running <= 1'b0;
    end
  end

  // last byte index for the stream
  always_ff @(posedge i_core_clk)
  begin
    if (!i_nrst)
      last_index <= `TWSC_BUF_AW'(`TWSC_COUNT_RESET);
    else if (wr_count & idle)
      last_index <= i_wdata[`TWSC_BUF_AW-1:0]; // up to 32 bytes
  end

  // byte pointer into the buffer
  always_ff @(posedge i_core_clk)
  begin
    if (!i_nrst)
      ptr <= '0;
    // every start restarts from the first byte
    else if (start)
      ptr <= '0;
    else if (byte_done & auto_more)
      ptr <= ptr_inc;
  end

  // shift register: bus write, load, shift in
  always_ff @(posedge i_core_clk)
  begin
    if (!i_nrst)
      shift_register <= 8'h00;
    else if (wr_shift & idle)
    begin
      // auto start takes its first byte from the buffer
      if (start & auto_transfer_enable)
        shift_register <= xfer_buf[0];
      else
        shift_register <= wr_view; // plain register too
    end
    else if (load_next)
      shift_register <= xfer_buf[ptr];
    else if (rise_ev & en)
      shift_register <= rx_byte;
  end

  // transmit latch: low on write, next bit on fall
  always_ff @(posedge i_core_clk)
  begin
    if (!i_nrst)
      so_latch <= 1'b0;
    // forced low even mid-byte; the next fall restores it
    else if (wr_shift)
      so_latch <= 1'b0;
    else if (fall_ev)
      so_latch <= shift_register[7];
  end

  // serial clock counter, cleared while disabled
  always_ff @(posedge i_core_clk)
  begin
    if (!i_nrst)
      bit_cnt <= 3'h0;
    else if (!en || start || load_next)
      bit_cnt <= 3'h0;
    else if (rise_ev)
      bit_cnt <= bit_cnt + 3'h1;
  end

  // internal clock: toggles during a byte, else high
  always_ff @(posedge i_core_clk)
  begin
    if (!i_nrst)
      sck_q <= 1'b1;
    // never toggles while stopped, external or between bytes
    else if (!en || ext || !xfer)
      sck_q <= 1'b1;
    else if (int_tick)
      sck_q <= ~sck_q;
  end

  // previous synced external clock level
  always_ff @(posedge i_core_clk)
  begin
    if (!i_nrst)
      // idle level, so no false edge follows reset
      sck_prev <= 1'b1;
    else
      sck_prev <= sck_s;
  end

  // buffer: bus writes while idle, received bytes stored
  always_ff @(posedge i_core_clk)
  begin
    // no reset: contents undefined until written
    if (wr_buf)
      xfer_buf[buf_idx] <= i_wdata;
    else if (byte_done & auto_transfer_enable & re)
      xfer_buf[ptr] <= rx_byte;
  end

  // flag: hardware set beats software clear
  always_ff @(posedge i_core_clk)
  begin
    if (!i_nrst)
      o_channel_irq_flag <= 1'b0;
    else if (byte_done)
      o_channel_irq_flag <= 1'b1;
    // a byte end and a clear in one cycle leave it set
    else if (wr_stat)
      o_channel_irq_flag <= 1'b0;
  end

  // read data selection
  logic [7:0] rd_mux;
  always_comb
  begin
    // unmapped addresses read as zero
    rd_mux = 8'h00;
    if (i_addr == `TWSC_MODE_ADDR)
      rd_mux = serial_mode_control;
    else if (i_addr == `TWSC_SHIFT_ADDR)
      rd_mux = rd_view;
    else if (i_addr == `TWSC_AUTO_ADDR)
      rd_mux = auto_transfer_control;
    else if (i_addr == `TWSC_COUNT_ADDR)
      rd_mux = 8'(last_index);
    else if (i_addr == `TWSC_STAT_ADDR)
      rd_mux = 8'(o_channel_irq_flag);
    else if (in_buf)
      rd_mux = xfer_buf[buf_idx];
  end

  // registered read data
  always_ff @(posedge i_core_clk)
  begin
    if (!i_nrst)
      o_rdata <= 8'h00;
    else if (i_rd)
      o_rdata <= rd_mux;
  end

  // pin drives; all released while stopped
  always_ff @(posedge i_core_clk)
  begin
    if (!i_nrst)
    begin
      o_serial_clock_pin <= 2'b10;
      o_serial_out_pin <= 2'b00;
      o_strobe_pin <= 2'b00;
      o_serial_in_used <= 1'b0;
      o_busy_in_used <= 1'b0;
    end
    else
    begin
      // clock driven only for internal sources
      o_serial_clock_pin.o <= sck_q;
      o_serial_clock_pin.oe <= en & ~ext;
      o_serial_out_pin.o <= so_latch;
      o_serial_out_pin.oe <= en;
      // strobe high for one tick between bytes
      o_strobe_pin.o <= (state == twsc_pkg::TWSC_STROBE);
      o_strobe_pin.oe <= en & auto_transfer_enable & stb_en;
      // input pins claimed only when used
      o_serial_in_used <= en & (~auto_transfer_enable | re);
      o_busy_in_used <= en & auto_transfer_enable & bsy_en;
    end
  end
endmodule : twsc_channel

// file: dv/twsc_far_end.sv
// far-end chip model: clocked serial slave with strobe and busy answer
`timescale 1ns/1ns
module twsc_far_end (
  input wire logic i_core_clk,
  input wire logic i_nrst,
  input wire logic i_sck,
  input wire logic i_sdo,
  input wire logic i_strobe,
  input wire logic [7:0] i_tx,
  input wire logic [7:0] i_hold,
  output logic o_sdi,
  output logic o_busy,
  output logic [7:0] o_rx,
  output int o_strobes,
  output int o_bad
);
  logic [7:0] sh = 8'h00; // receive shifter
  logic [7:0] tx = 8'h00; // transmit shifter
  int nb = 0; // bits of current byte
  // idle levels
  initial
  begin
    o_sdi = 1'b0;
    o_busy = 1'b0;
    o_rx = 8'h00;
    o_strobes = 0;
    o_bad = 0;
  end
  // next bit out on each falling clock, msb first; busy must hold it off
  always @(negedge i_sck)
    if (i_nrst)
    begin
      if (nb == 0)
        tx = i_tx;
      o_sdi = tx[7];
      tx = {tx[6:0], ~tx[7]};
      if (o_busy)
        o_bad++;
    end
  // capture on each rising clock; line flips once the byte is done
  always @(posedge i_sck)
    if (i_nrst)
    begin
      sh = {sh[6:0], i_sdo};
      nb++;
      if (nb == 8)
      begin
        o_rx = sh;
        nb = 0;
        o_sdi <= #250 ~o_sdi;
      end
    end
  // busy for a while after each strobe
  always @(posedge i_strobe)
  begin
    o_strobes++;
    o_busy = 1'b1;
    repeat (i_hold) @(posedge i_core_clk);
    #1 o_busy = 1'b0;
  end
endmodule : twsc_far_end

// file: dv/twsc_channel_assertions.sv
// port checker for the three-wire serial channel
`timescale 1ns/1ns
`include "twsc_defines.svh"
module twsc_channel_assertions (
  input wire logic i_core_clk,
  input wire logic i_nrst,
  input wire logic [15:0] i_addr,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic [7:0] i_wdata,
  input wire logic [7:0] o_rdata,
  input wire twsc_pkg::twsc_pin_t o_serial_clock_pin,
  input wire twsc_pkg::twsc_pin_t o_serial_out_pin,
  input wire twsc_pkg::twsc_pin_t o_strobe_pin,
  input wire logic o_serial_in_used,
  input wire logic o_busy_in_used,
  input wire logic o_channel_irq_flag
);
  logic [7:0] mode_copy; // mirror of mode register
  logic clk_last; // clock level one cycle ago
  logic [3:0] n_falls; // clock falls since start
  wire wr_shift = i_wr && i_addr == `TWSC_SHIFT_ADDR;
  wire clk_fall = clk_last && !o_serial_clock_pin.o && o_serial_clock_pin.oe;
  // mirror and fall counter
  always_ff @(posedge i_core_clk)
  begin
    clk_last <= o_serial_clock_pin.o;
    if (!i_nrst)
    begin
      mode_copy <= 8'h00;
      n_falls <= 4'h0;
    end
    else
    begin
      if (i_wr && i_addr == `TWSC_MODE_ADDR)
        mode_copy <= i_wdata & `TWSC_MODE_WMASK;
      if (wr_shift)
        n_falls <= 4'h0;
      else if (clk_fall)
        n_falls <= n_falls + 4'h1;
    end
  end
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (!i_nrst);
  reset_out_a: assert property ($rose(i_nrst) |->
    o_rdata == 8'h00 && !o_channel_irq_flag) else $error("outputs not cleared");
  mode_read_a: assert property (i_rd && i_addr == `TWSC_MODE_ADDR |=>
    o_rdata == mode_copy) else $error("mode readback wrong");
  stop_release_a: assert property (!mode_copy[7] && !$past(mode_copy[7]) |->
    !(o_serial_out_pin.oe || o_serial_clock_pin.oe || o_strobe_pin.oe
    || o_serial_in_used || o_busy_in_used)) else $error("pins kept while stopped");
  stop_idle_a: assert property (!mode_copy[7] && !$past(mode_copy[7]) &&
    !$past(mode_copy[7], 2) |-> o_serial_clock_pin.o)
    else $error("clock moved while stopped");
  clock_dir_a: assert property (mode_copy[7] && mode_copy == $past(mode_copy) |->
    o_serial_clock_pin.oe == mode_copy[1]) else $error("clock pin direction wrong");
  eight_bits_a: assert property ($rose(o_channel_irq_flag) && !mode_copy[5]
    && o_serial_clock_pin.oe |-> n_falls == 4'h8) else $error("byte not eight clocks");
  done_high_a: assert property ($rose(o_channel_irq_flag) &&
    o_serial_clock_pin.oe |-> ##[0:1] o_serial_clock_pin.o) else $error("clock low idle");
  out_latch_a: assert property (o_serial_out_pin.oe && $past(o_serial_out_pin.oe)
    && o_serial_clock_pin.oe && $changed(o_serial_out_pin.o) |-> clk_fall
    || $past(wr_shift, 2)) else $error("output moved off falling edge");
  strobe_gate_a: assert property (o_strobe_pin.oe |->
    $past(mode_copy[7] && mode_copy[5])) else $error("strobe outside auto mode");
endmodule : twsc_channel_assertions
bind twsc_channel twsc_channel_assertions i_twsc_channel_assertions (.i_core_clk,
  .i_nrst, .i_addr, .i_wr, .i_rd, .i_wdata, .o_rdata, .o_serial_clock_pin,
  .o_serial_out_pin, .o_strobe_pin, .o_serial_in_used, .o_busy_in_used,
  .o_channel_irq_flag);

// file: dv/test_twsc_channel.sv
// self-checking bench for the three-wire serial channel
`timescale 1ns/1ns
`include "twsc_defines.svh"
module test_twsc_channel;
  logic i_core_clk = 0, i_nrst = 0, i_wr = 0, i_rd = 0, ext_clk = 1;
  logic i_timer_two_tick = 0, i_prescale_tick = 0, sdi, busy;
  logic [15:0] i_addr = 16'h0000;
  logic [7:0] i_wdata = 8'h00, o_rdata, got, w, m, rx, tx = 8'h00, hold = 8'h04;
  twsc_pkg::twsc_pin_t o_serial_clock_pin, o_serial_out_pin, o_strobe_pin;
  logic o_serial_in_used, o_busy_in_used, o_channel_irq_flag;
  int n_errors = 0, check_count = 0, tick_n = 0, strobes, bad;
  // clock pin wire: channel drives it, else the bench-driven ext_clk
  wire sck = o_serial_clock_pin.oe ? o_serial_clock_pin.o : ext_clk;
  initial forever #50 i_core_clk = ~i_core_clk;
  // rate pulses: prescaler every 4 cycles, timer two every 6
  always @(posedge i_core_clk)
  begin
    #1;
    tick_n++;
    i_prescale_tick = (tick_n % 4 == 0);
    i_timer_two_tick = (tick_n % 6 == 0);
  end
  twsc_channel i_twsc_channel (.i_core_clk, .i_nrst, .i_addr, .i_wr, .i_rd, .i_wdata,
    .i_timer_two_tick, .i_prescale_tick, .i_serial_clock_pin(sck), .i_serial_in_pin(sdi),
    .i_busy_pin(busy), .o_rdata, .o_serial_clock_pin, .o_serial_out_pin, .o_strobe_pin,
    .o_serial_in_used, .o_busy_in_used, .o_channel_irq_flag);
  twsc_far_end i_twsc_far_end (.i_core_clk, .i_nrst, .i_sck(sck),
    .i_sdo(o_serial_out_pin.o), .i_strobe(o_strobe_pin.o & o_strobe_pin.oe), .i_tx(tx),
    .i_hold(hold), .o_sdi(sdi), .o_busy(busy), .o_rx(rx), .o_strobes(strobes), .o_bad(bad));
  // compare and count
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    check_count++;
    if (g !== e)
    begin
      n_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk
  // one bus cycle; read data lands in got
  task automatic bus(input logic [15:0] a, input logic [7:0] d, input logic r);
    @(posedge i_core_clk);
    #1;
    i_addr = a;
    i_wdata = d;
    i_wr = !r;
    i_rd = r;
    @(posedge i_core_clk);
    #1;
    i_wr = 0;
    i_rd = 0;
    got = o_rdata;
  endtask : bus
  // bounded wait for the done flag
  task automatic wait_flag();
    for (int i = 0; i < 3000 && o_channel_irq_flag !== 1'b1; i++)
    begin
      @(posedge i_core_clk);
      #1;
    end
    chk({7'h00, o_channel_irq_flag}, 8'h01);
  endtask : wait_flag
  // bit reversal
  function automatic logic [7:0] rev8(input logic [7:0] v);
    for (int k = 0; k < 8; k++)
      rev8[k] = v[7 - k];
  endfunction : rev8
  // verdict and end of run
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : give_verdict
  // watchdog
  initial
  begin
    #500000;
    n_errors++;
    give_verdict();
  end
  // main sequence
  initial
  begin
    void'($urandom(28549));
    repeat (16) @(posedge i_core_clk);
    #1 i_nrst = 1;
    bus(`TWSC_AUTO_ADDR, 8'h00, 1);
    chk(got, 8'h00);
    bus(`TWSC_MODE_ADDR, 8'h1C, 0);
    bus(`TWSC_MODE_ADDR, 8'h00, 1);
    chk(got, 8'h00);
    w = $urandom;
    bus(`TWSC_SHIFT_ADDR, w, 0);
    bus(`TWSC_MODE_ADDR, 8'h83, 0);
    repeat (200) @(posedge i_core_clk);
    chk({7'h00, o_channel_irq_flag}, 8'h00);
    bus(`TWSC_SHIFT_ADDR, 8'h00, 1);
    chk(got, w);
    $display("test stopped mode done");
    for (int n = 0; n < 6; n++)
    begin
      m = 8'(32'h80 | ($urandom & 32'h40) | (n % 3 + 1));
      w = $urandom;
      tx = $urandom;
      bus(`TWSC_MODE_ADDR, m, 0);
      bus(`TWSC_SHIFT_ADDR, w, 0);
      // registered pin shows the forced low one edge after the write
      @(posedge i_core_clk);
      #1;
      chk({7'h00, o_serial_out_pin.o}, 8'h00);
      chk({5'h00, o_serial_in_used, o_busy_in_used, o_serial_out_pin.oe}, 8'h05);
      chk({7'h00, o_serial_clock_pin.oe}, {7'h00, m[1]});
      if (!m[1])
      begin
        #37;
        repeat (8)
        begin
          #400 ext_clk = 0;
          #400 ext_clk = 1;
        end
      end
      wait_flag();
      bus(`TWSC_SHIFT_ADDR, 8'h00, 1);
      chk(got, m[6] ? rev8(tx) : tx);
      if (m[1])
        chk(rx, m[6] ? rev8(w) : w);
      bus(`TWSC_STAT_ADDR, 8'h00, 0);
    end
    $display("test plain transfers done");
    for (int k = 0; k < 3; k++)
    begin
      w = $urandom;
      bus(`TWSC_BUF_BASE + 16'(k), w, 0);
    end
    tx = $urandom;
    hold = 8'(5 + $urandom % 20);
    bus(`TWSC_COUNT_ADDR, 8'h02, 0);
    bus(`TWSC_AUTO_ADDR, 8'h86, 0);
    bus(`TWSC_MODE_ADDR, 8'hA3, 0);
    bus(`TWSC_SHIFT_ADDR, 8'h00, 0);
    chk({5'h00, o_serial_in_used, o_busy_in_used, o_strobe_pin.oe}, 8'h07);
    got = 8'h08;
    for (int i = 0; i < 3000 && got[3]; i++)
      bus(`TWSC_AUTO_ADDR, 8'h00, 1);
    chk(got & 8'h08, 8'h00);
    for (int k = 0; k < 3; k++)
    begin
      bus(`TWSC_BUF_BASE + 16'(k), 8'h00, 1);
      chk(got, tx);
    end
    chk(rx, w);
    chk(8'(strobes), 8'h02);
    chk(8'(bad), 8'h00);
    $display("test automatic mode done");
    give_verdict();
  end
endmodule : test_twsc_channel
